// File: mfc_pkg.sv
// Package of constants and types for the multi function counter
package mfc_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned NUM_PINS = 3;

	// ----------------------------------------------------------------
	// Pin positions inside the synchronised pin vector
	// ----------------------------------------------------------------
	localparam int unsigned PIN_A = 0;
	localparam int unsigned PIN_B = 1;
	localparam int unsigned PIN_LATCH = 2;

	// ----------------------------------------------------------------
	// Register word addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_CTRL = 16'h0000;
	localparam logic [15:0] ADDR_UPPER = 16'h0001;
	localparam logic [15:0] ADDR_LOWER = 16'h0002;
	localparam logic [15:0] ADDR_ADD = 16'h0003;
	localparam logic [15:0] ADDR_PRESET = 16'h0004;
	localparam logic [15:0] ADDR_CMPA = 16'h0005;
	localparam logic [15:0] ADDR_CMPB = 16'h0006;
	localparam logic [15:0] ADDR_CLKDIV = 16'h0007;
	localparam logic [15:0] ADDR_COUNT = 16'h0008;
	localparam logic [15:0] ADDR_STATUS = 16'h0009;
	localparam logic [15:0] ADDR_LATCH = 16'h03E8;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_W = 6;
	localparam int unsigned CTRL_EN = 0;
	localparam int unsigned CTRL_MODE_LO = 1;
	localparam int unsigned CTRL_MODE_HI = 2;
	localparam int unsigned CTRL_ADD_EN = 3;
	localparam int unsigned CTRL_LATCH_FALL = 4;
	localparam int unsigned CTRL_STOP_PRESET = 5;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int unsigned STAT_RUN = 0;
	localparam int unsigned STAT_CMP = 1;
	localparam int unsigned STAT_PULSE = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [31:0] UPPER_RST = 32'h0000_0014;
	localparam logic [31:0] LOWER_RST = 32'h0000_0000;
	localparam logic [31:0] ADD_RST = 32'h0000_0001;
	localparam logic [31:0] PRESET_RST = 32'h0000_0000;
	localparam logic [31:0] CMPA_RST = 32'h0000_000A;
	localparam logic [31:0] CMPB_RST = 32'h0000_0013;
	localparam logic [15:0] CLKDIV_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned PULSE_WIDTH_MS = 1;
	localparam int unsigned PULSE_CYCLES = PULSE_WIDTH_MS * 1000000 / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_TIMER,
		MODE_UPDOWN,
		MODE_RATIO,
		MODE_SPARE
	} mode_e;

endpackage : mfc_pkg

// File: multi_function_counter.sv
// Multi function counter: fixed cycle output, latch, up/down and ratio
// ----------------------------------------------------------------
// Contract
// - A rise on input A starts timer output, one compare pulse per cycle.
// - A rise on input B stops timer output.
// - A latch event copies the current count into the latch register.
// - Every later latch event overwrites the latch register.
// - Latch detection can be set to the falling edge of the latch pin.
// - Two-phase x1 decoding: forward event counts up, reverse counts down.
// - The latch value is readable by the host at address 1000.
// - Ratio mode limits the step to half the upper limit, ratio at most one.
// - Ratio mode counts both edges of input A and nothing else.
// - Ratio equals step over half the upper limit, step added per edge.
// - Compare output is high while count lies in the set range, in timer mode only while running.
// - Each compare rise holds the output pulse high for a fixed 1ms from that rise; a rise during a pulse restarts it.
// - Ring period equals upper minus lower counter clock periods.
// ----------------------------------------------------------------
`timescale 1ns/100ps
module multi_function_counter #(
	parameter int unsigned PULSE_CYCLES = mfc_pkg::PULSE_CYCLES
) (
	input wire logic i_clk,            // System clock, 50 MHz
	input wire logic i_rst,            // Synchronous reset, active high
	input wire logic [15:0] i_addr,    // Register word address
	input wire logic [31:0] i_wdata,   // Write data
	input wire logic i_wr,             // Write strobe
	input wire logic i_rd,             // Read strobe
	output logic [31:0] o_rdata,       // Read data, cycle after strobe
	input wire logic i_in_a,           // Start pin / phase A / ratio input
	input wire logic i_in_b,           // Stop pin / phase B
	input wire logic i_latch,          // Latch pin
	output logic o_cmp,                // Compare output
	output logic o_pulse,              // Fixed width output pulse
	output logic o_running             // Timer output active
);
	// ----------------------------------------------------------------
	// Pin conditioning
	// ----------------------------------------------------------------
	pin_edge_if #(.N(mfc_pkg::NUM_PINS)) ev ();

	pin_sync #(.N(mfc_pkg::NUM_PINS)) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pins({i_latch, i_in_b, i_in_a}),
		.o_ev(ev.src)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [5:0] ctrl;
	logic [31:0] upper;
	logic [31:0] lower;
	logic [31:0] add_val;
	logic [31:0] preset;
	logic [31:0] cmpa;
	logic [31:0] cmpb;
	logic [15:0] clkdiv;
	logic [31:0] count;
	logic [31:0] latch_val;
	logic run;
	logic cmp_q;
	logic pulse_q;
	logic [31:0] pulse_cnt;
	logic [15:0] div_cnt;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	mfc_pkg::mode_e mode;
	wire en = ctrl[mfc_pkg::CTRL_EN];
	wire add_en = ctrl[mfc_pkg::CTRL_ADD_EN];
	wire latch_fall = ctrl[mfc_pkg::CTRL_LATCH_FALL];
	wire stop_preset = ctrl[mfc_pkg::CTRL_STOP_PRESET];
	assign mode = mfc_pkg::mode_e'(ctrl[mfc_pkg::CTRL_MODE_HI:mfc_pkg::CTRL_MODE_LO]);
	wire is_timer = (mode == mfc_pkg::MODE_TIMER);
	wire is_updown = (mode == mfc_pkg::MODE_UPDOWN);
	wire is_ratio = (mode == mfc_pkg::MODE_RATIO);

	wire rise_a = ev.rise[mfc_pkg::PIN_A];
	wire fall_a = ev.fall[mfc_pkg::PIN_A];
	wire rise_b = ev.rise[mfc_pkg::PIN_B];
	wire level_b = ev.level[mfc_pkg::PIN_B];
	wire rise_l = ev.rise[mfc_pkg::PIN_LATCH];
	wire fall_l = ev.fall[mfc_pkg::PIN_LATCH];

	// Counter clock: one-cycle enable every clkdiv+1 system clocks
	wire tick = (div_cnt == clkdiv);

	// Start and stop only act in timer mode
	wire start_evt = is_timer && en && rise_a;
	wire stop_evt = is_timer && rise_b;

	// Count events per mode; ratio mode ignores input B entirely
	wire inc_timer = is_timer && run && tick;
	wire inc_ud = is_updown && en && rise_a && !level_b;
	wire dec_ud = is_updown && en && fall_a && !level_b;
	wire inc_ratio = is_ratio && en && (rise_a || fall_a);
	wire inc = inc_timer || inc_ud || inc_ratio;
	wire dec = dec_ud;

	// Step size; a step above half the range would exceed ratio one
	wire [31:0] half_upper = upper >> 1;
	wire add_clamp = is_ratio && (add_val > half_upper);
	wire [31:0] add_eff = add_clamp ? half_upper : add_val;
	wire [31:0] step = add_en ? add_eff : 32'h0000_0001;
	wire [31:0] span = upper - lower;

	// Ring arithmetic in 33 bits so the sum cannot overflow
	wire [32:0] sum = {1'b0, count} + {1'b0, step};
	wire up_wrap = (sum >= {1'b0, upper});
	wire [32:0] up_wrapped = sum - {1'b0, span};
	wire [31:0] up_next = up_wrap ? up_wrapped[31:0] : sum[31:0];
	wire [32:0] low_lim = {1'b0, lower} + {1'b0, step};
	wire dn_wrap = ({1'b0, count} < low_lim);
	wire [31:0] dn_next = dn_wrap ? (count + span - step) : (count - step);

	wire [31:0] next_count = (stop_evt && stop_preset) ? preset :
		inc ? up_next :
		dec ? dn_next : count;

	// Stop beats start when both pins rise in the same cycle
	wire next_run = stop_evt ? 1'b0 : (start_evt ? 1'b1 : run);

	// Range compare; timer mode gates it with run
	wire in_range = (count >= cmpa) && (count <= cmpb);
	wire cmp_gated = in_range && (!is_timer || run);
	wire cmp_rise = cmp_gated && !cmp_q;

	wire latch_evt = latch_fall ? fall_l : rise_l;

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	wire wr_ctrl = i_wr && (i_addr == mfc_pkg::ADDR_CTRL);
	wire wr_upper = i_wr && (i_addr == mfc_pkg::ADDR_UPPER);
	wire wr_lower = i_wr && (i_addr == mfc_pkg::ADDR_LOWER);
	wire wr_add = i_wr && (i_addr == mfc_pkg::ADDR_ADD);
	wire wr_preset = i_wr && (i_addr == mfc_pkg::ADDR_PRESET);
	wire wr_cmpa = i_wr && (i_addr == mfc_pkg::ADDR_CMPA);
	wire wr_cmpb = i_wr && (i_addr == mfc_pkg::ADDR_CMPB);
	wire wr_clkdiv = i_wr && (i_addr == mfc_pkg::ADDR_CLKDIV);

	wire [31:0] status = {29'h0000_0000, pulse_q, cmp_q, run};
	wire [31:0] rd_mux =
		(i_addr == mfc_pkg::ADDR_CTRL) ? {26'h000_0000, ctrl} :
		(i_addr == mfc_pkg::ADDR_UPPER) ? upper :
		(i_addr == mfc_pkg::ADDR_LOWER) ? lower :
		(i_addr == mfc_pkg::ADDR_ADD) ? add_val :
		(i_addr == mfc_pkg::ADDR_PRESET) ? preset :
		(i_addr == mfc_pkg::ADDR_CMPA) ? cmpa :
		(i_addr == mfc_pkg::ADDR_CMPB) ? cmpb :
		(i_addr == mfc_pkg::ADDR_CLKDIV) ? {16'h0000, clkdiv} :
		(i_addr == mfc_pkg::ADDR_COUNT) ? count :
		(i_addr == mfc_pkg::ADDR_STATUS) ? status :
		(i_addr == mfc_pkg::ADDR_LATCH) ? latch_val : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl <= mfc_pkg::CTRL_RST;
			upper <= mfc_pkg::UPPER_RST;
			lower <= mfc_pkg::LOWER_RST;
			add_val <= mfc_pkg::ADD_RST;
			preset <= mfc_pkg::PRESET_RST;
			cmpa <= mfc_pkg::CMPA_RST;
			cmpb <= mfc_pkg::CMPB_RST;
			clkdiv <= mfc_pkg::CLKDIV_RST;
		end else begin
			if (wr_ctrl) ctrl <= i_wdata[5:0];
			if (wr_upper) upper <= i_wdata;
			if (wr_lower) lower <= i_wdata;
			if (wr_add) add_val <= i_wdata;
			if (wr_preset) preset <= i_wdata;
			if (wr_cmpa) cmpa <= i_wdata;
			if (wr_cmpb) cmpb <= i_wdata;
			if (wr_clkdiv) clkdiv <= i_wdata[15:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) o_rdata <= 32'h0000_0000;
		else if (i_rd) o_rdata <= rd_mux;
	end

	// ----------------------------------------------------------------
	// Counter clock divider
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst || tick || !run) div_cnt <= 16'h0000;
		else div_cnt <= div_cnt + 16'h0001;
	end

	// ----------------------------------------------------------------
	// Counter, run flag and latch
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count <= mfc_pkg::PRESET_RST;
			run <= 1'b0;
			latch_val <= 32'h0000_0000;
		end else begin
			count <= next_count;
			run <= next_run;
			if (latch_evt) latch_val <= count;
		end
	end

	// ----------------------------------------------------------------
	// Compare output and fixed width pulse
	// ----------------------------------------------------------------
	// A compare rise during a pulse restarts the width count.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cmp_q <= 1'b0;
			pulse_q <= 1'b0;
			pulse_cnt <= 32'h0000_0000;
		end else begin
			cmp_q <= cmp_gated;
			if (cmp_rise) begin
				pulse_q <= 1'b1;
				pulse_cnt <= 32'(PULSE_CYCLES);
			end else if (pulse_cnt != 32'h0000_0000) begin
				pulse_cnt <= pulse_cnt - 32'h0000_0001;
				pulse_q <= (pulse_cnt != 32'h0000_0001);
			end
		end
	end

	assign o_cmp = cmp_q;
	assign o_pulse = pulse_q;
	assign o_running = run;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_cmp_rise;
		cmp_rise;
	endsequence

	sequence s_pulse_lead;
		o_pulse && (pulse_cnt == 32'(PULSE_CYCLES)) ##1 o_pulse;
	endsequence

	property p_start;
		start_evt && !stop_evt |=> run && o_running;
	endproperty
	a_start: assert property (p_start) else $error("start did not run");

	property p_stop;
		stop_evt |=> !run && (!$past(stop_preset) || count == $past(preset));
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt");

	property p_latch;
		latch_evt |=> latch_val == $past(count);
	endproperty
	a_latch: assert property (p_latch) else $error("latch missed count");

	property p_latch_hold;
		!latch_evt |=> $stable(latch_val);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved");

	property p_latch_rise;
		!latch_fall && rise_l |=> latch_val == $past(count);
	endproperty
	a_latch_rise: assert property (p_latch_rise) else $error("rise latch lost");

	property p_updown;
		inc_ud && !up_wrap |=> count == $past(count) + $past(step);
	endproperty
	a_updown: assert property (p_updown) else $error("up count wrong");

	property p_read_latch;
		i_rd && i_addr == mfc_pkg::ADDR_LATCH |=> o_rdata == $past(latch_val);
	endproperty
	a_read_latch: assert property (p_read_latch) else $error("latch read wrong");

	property p_ratio_step;
		is_ratio && add_en |-> step <= half_upper;
	endproperty
	a_ratio_step: assert property (p_ratio_step) else $error("ratio above one");

	property p_ratio_idle;
		is_ratio && !rise_a && !fall_a |=> $stable(count);
	endproperty
	a_ratio_idle: assert property (p_ratio_idle) else $error("ratio counted");

	property p_ring;
		count >= lower && count < upper && inc && !stop_evt
			|=> count >= lower && count < upper;
	endproperty
	a_ring: assert property (p_ring) else $error("ring out of range");

	property p_range;
		!is_timer && count >= cmpa && count <= cmpb |=> o_cmp;
	endproperty
	a_range: assert property (p_range) else $error("compare low in range");

	property p_pulse;
		s_cmp_rise |=> s_pulse_lead;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse did not start");

	property p_pulse_cause;
		$rose(o_pulse) |-> $past(cmp_rise);
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("stray pulse");

	property p_timer_tick;
		is_timer && run && !tick && !stop_evt |=> $stable(count);
	endproperty
	a_timer_tick: assert property (p_timer_tick) else $error("count off tick");

endmodule : multi_function_counter

// File: multi_function_counter_tb.sv
// Self-checking testbench of the multi function counter
`timescale 1ns/100ps
module multi_function_counter_tb;
	localparam int unsigned PW = 4;
	logic i_clk;
	logic i_rst;
	logic i_wr;
	logic i_rd;
	logic [15:0] i_addr;
	logic [31:0] i_wdata;
	logic [31:0] o_rdata;
	logic [31:0] base;
	logic a;
	logic b;
	logic l;
	logic o_cmp;
	logic o_pulse;
	logic o_running;
	logic cmp_q = 1'h0;
	logic pulse_q = 1'h0;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int cmp_n = 0;
	int pulse_n = 0;
	int t_prev = 0;
	int t_last = 0;

	multi_function_counter #(.PULSE_CYCLES(PW)) i_dut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_in_a(a),
		.i_in_b(b),
		.i_latch(l),
		.o_cmp(o_cmp),
		.o_pulse(o_pulse),
		.o_running(o_running)
	);

	pin_world i_pins (.i_clk(i_clk), .o_a(a), .o_b(b), .o_latch(l));

	initial begin
		i_clk = 1'h0;
		forever #10 i_clk = ~i_clk;
	end

	// ----------------------------------------------------------------
	// Monitor and timeout
	// ----------------------------------------------------------------
	// Whole run needs about 600 cycles; 5000 leaves ample margin
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		cmp_q <= o_cmp;
		pulse_q <= o_pulse;
		if (o_cmp === 1'h1 && cmp_q === 1'h0) begin
			cmp_n <= cmp_n + 1;
			t_prev <= t_last;
			t_last <= cyc;
		end
		if (o_pulse === 1'h1 && pulse_q === 1'h0) begin
			pulse_n <= pulse_n + 1;
		end
		if (cyc == 5000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	task automatic wr(input logic [15:0] ad, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1'h1;
		i_addr <= ad;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [15:0] ad, output logic [31:0] v);
		@(posedge i_clk);
		i_rd <= 1'h1;
		i_addr <= ad;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1;
		v = o_rdata;
	endtask : rd

	task automatic rchk(input string name, input logic [15:0] ad, input logic [31:0] exp);
		logic [31:0] v;
		rd(ad, v);
		chk(name, v, exp);
	endtask : rchk

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk("ctrl", mfc_pkg::ADDR_CTRL, 32'h0);
		rchk("upper", mfc_pkg::ADDR_UPPER, 32'h14);
		rchk("add", mfc_pkg::ADDR_ADD, 32'h1);
		rchk("cmpa", mfc_pkg::ADDR_CMPA, 32'hA);
		rchk("cmpb", mfc_pkg::ADDR_CMPB, 32'h13);
		rchk("lower", mfc_pkg::ADDR_LOWER, 32'h0);
		rchk("preset reg", mfc_pkg::ADDR_PRESET, 32'h0);
		rchk("clkdiv", mfc_pkg::ADDR_CLKDIV, 32'h0);
		rchk("count", mfc_pkg::ADDR_COUNT, 32'h0);
		rchk("status", mfc_pkg::ADDR_STATUS, 32'h0);
		rchk("latch", mfc_pkg::ADDR_LATCH, 32'h0);
		rchk("unmapped", 16'h00FF, 32'h0);
	endtask : t_reset

	task automatic t_timer();
		int n0;
		int p0;
		wr(mfc_pkg::ADDR_CMPA, 32'h5);
		wr(mfc_pkg::ADDR_CMPB, 32'h5);
		wr(mfc_pkg::ADDR_CTRL, 32'h21);
		n0 = cmp_n;
		p0 = pulse_n;
		i_pins.set(3'h1);
		i_pins.set(3'h0);
		chk("running", o_running, 32'h1);
		for (int k = 0; k < 80 && cmp_n < n0 + 2; k++) @(posedge i_clk);
		repeat (2) @(posedge i_clk);
		chk("period", t_last - t_prev, 32'h14);
		chk("pulses", pulse_n - p0, 32'h2);
		i_pins.set(3'h2);
		i_pins.set(3'h0);
		chk("stopped", o_running, 32'h0);
		n0 = cmp_n;
		repeat (50) @(posedge i_clk);
		chk("cmp after stop", cmp_n - n0, 32'h0);
		rchk("preset", mfc_pkg::ADDR_COUNT, 32'h0);
	endtask : t_timer

	task automatic t_ratio();
		int p0;
		wr(mfc_pkg::ADDR_ADD, 32'h3);
		wr(mfc_pkg::ADDR_CMPA, 32'hA);
		wr(mfc_pkg::ADDR_CMPB, 32'h13);
		wr(mfc_pkg::ADDR_CTRL, 32'hD);
		p0 = pulse_n;
		repeat (10) begin
			i_pins.set(3'h1);
			i_pins.set(3'h0);
		end
		repeat (4) @(posedge i_clk);
		chk("ratio pulses", pulse_n - p0, 32'h3);
		rchk("ratio count", mfc_pkg::ADDR_COUNT, 32'h0);
		i_pins.set(3'h2);
		i_pins.set(3'h0);
		rchk("b ignored", mfc_pkg::ADDR_COUNT, 32'h0);
		wr(mfc_pkg::ADDR_ADD, 32'hF);
		p0 = pulse_n;
		repeat (2) begin
			i_pins.set(3'h1);
			i_pins.set(3'h0);
		end
		repeat (4) @(posedge i_clk);
		chk("clamped pulses", pulse_n - p0, 32'h2);
		rchk("clamped count", mfc_pkg::ADDR_COUNT, 32'h0);
	endtask : t_ratio

	task automatic t_updown();
		wr(mfc_pkg::ADDR_ADD, 32'h1);
		wr(mfc_pkg::ADDR_CTRL, 32'h3);
		rd(mfc_pkg::ADDR_COUNT, base);
		repeat (5) i_pins.fwd();
		i_pins.set(3'h4);
		i_pins.set(3'h0);
		rchk("latch up", mfc_pkg::ADDR_LATCH, base + 32'h5);
		repeat (2) i_pins.rev();
		rchk("count down", mfc_pkg::ADDR_COUNT, base + 32'h3);
		i_pins.set(3'h4);
		i_pins.set(3'h0);
		wr(mfc_pkg::ADDR_LATCH, 32'hFF);
		rchk("latch again", mfc_pkg::ADDR_LATCH, base + 32'h3);
		repeat (4) i_pins.rev();
		rchk("wrap down", mfc_pkg::ADDR_COUNT, base + 32'h13);
		chk("cmp in range", o_cmp, 32'h1);
		i_pins.fwd();
		chk("cmp out of range", o_cmp, 32'h0);
		// Latch on the falling edge: one forward step while the latch pin is high
		wr(mfc_pkg::ADDR_CTRL, 32'h13);
		i_pins.set(3'h4);
		i_pins.set(3'h5);
		i_pins.set(3'h7);
		i_pins.set(3'h6);
		i_pins.set(3'h4);
		i_pins.set(3'h0);
		rchk("latch fall", mfc_pkg::ADDR_LATCH, 32'h1);
	endtask : t_updown

	// Timer with a divided counter clock and a raised lower limit
	task automatic t_ring();
		logic [31:0] v;
		int n0;
		wr(mfc_pkg::ADDR_CLKDIV, 32'h1);
		wr(mfc_pkg::ADDR_LOWER, 32'hC);
		wr(mfc_pkg::ADDR_PRESET, 32'hC);
		wr(mfc_pkg::ADDR_CMPA, 32'hE);
		wr(mfc_pkg::ADDR_CMPB, 32'hE);
		wr(mfc_pkg::ADDR_CTRL, 32'h21);
		i_pins.set(3'h2);
		i_pins.set(3'h0);
		rchk("stop preset", mfc_pkg::ADDR_COUNT, 32'hC);
		n0 = cmp_n;
		i_pins.set(3'h1);
		i_pins.set(3'h0);
		rd(mfc_pkg::ADDR_STATUS, v);
		chk("status run", v & 32'h0000_0001, 32'h1);
		for (int k = 0; k < 80 && cmp_n < n0 + 2; k++) @(posedge i_clk);
		repeat (2) @(posedge i_clk);
		chk("divided period", t_last - t_prev, 32'h10);
		i_pins.set(3'h2);
		i_pins.set(3'h0);
		rchk("status stopped", mfc_pkg::ADDR_STATUS, 32'h0);
		rchk("preset again", mfc_pkg::ADDR_COUNT, 32'hC);
	endtask : t_ring

	initial begin
		i_rst = 1'h1;
		i_wr = 1'h0;
		i_rd = 1'h0;
		i_addr = 16'h0;
		i_wdata = 32'h0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'h0;
		t_reset();
		t_timer();
		t_ratio();
		t_updown();
		t_ring();
		final_report();
	end
endmodule : multi_function_counter_tb

// File: pin_edge_if.sv
// Interface carrying synchronised pin levels and their edges
`timescale 1ns/100ps
interface pin_edge_if #(parameter int unsigned N = 3);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : pin_edge_if

// File: pin_sync.sv
// Two-stage pin synchroniser with rise and fall detection per pin
`timescale 1ns/100ps
module pin_sync #(
	parameter int unsigned N = 3
) (
	input wire logic i_clk,            // System clock
	input wire logic i_rst,            // Synchronous reset, active high
	input wire logic [N-1:0] i_pins,   // Asynchronous pins
	pin_edge_if.src o_ev               // Levels and edges
);
	logic [N-1:0] meta;
	logic [N-1:0] sync;
	logic [N-1:0] prev;

	// ----------------------------------------------------------------
	// Per-pin stages
	// ----------------------------------------------------------------
	// Edges come from the second and third stages only, so the
	// metastable first stage never reaches logic.
	for (genvar g = 0; g < N; g++) begin : g_pin
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				meta[g] <= 1'b0;
				sync[g] <= 1'b0;
				prev[g] <= 1'b0;
			end else begin
				meta[g] <= i_pins[g];
				sync[g] <= meta[g];
				prev[g] <= sync[g];
			end
		end
		assign o_ev.level[g] = sync[g];
		assign o_ev.rise[g] = sync[g] & ~prev[g];
		assign o_ev.fall[g] = ~sync[g] & prev[g];
	end
endmodule : pin_sync

// File: pin_world.sv
// Model of the external pins: start and stop pins, encoder phases, latch pin
`timescale 1ns/100ps
module pin_world (
	input wire logic i_clk,  // System clock
	output logic o_a,        // Start pin, phase A, ratio input
	output logic o_b,        // Stop pin, phase B
	output logic o_latch     // Latch pin
);
	initial begin
		o_a = 1'h0;
		o_b = 1'h0;
		o_latch = 1'h0;
	end

	// ----------------------------------------------------------------
	// Pin levels
	// ----------------------------------------------------------------
	// Each level is held 4 clocks so that the fastest counter clock misses no edge
	task automatic set(input logic [2:0] v);
		@(posedge i_clk);
		o_a <= v[0];
		o_b <= v[1];
		o_latch <= v[2];
		repeat (3) @(posedge i_clk);
	endtask : set

	// One forward step: A rises while B is low
	task automatic fwd();
		set(3'h1);
		set(3'h3);
		set(3'h2);
		set(3'h0);
	endtask : fwd

	// One reverse step: A falls while B is low
	task automatic rev();
		set(3'h2);
		set(3'h3);
		set(3'h1);
		set(3'h0);
	endtask : rev
endmodule : pin_world
